// File: verification/diag_fault_monitor.sv
// port checker for the diagnostic fault policy
// assumes it is bound onto diag_fault_policy
`timescale 1ns/1ps
module diag_fault_monitor
	import diag_fault_pkg::*;
(
	input wire logic       SYS_CLK,
	input wire logic       SYS_RST,
	input wire logic       REG_WR,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic       OT_RAW,
	input wire fault_vec_t FAULT_STATUS,
	input wire logic       MICBIAS_EN
);
	logic [7:0] act_q;
	wire        wa  = REG_WR && REG_ADDR == 8'h50;
	// shadow of the action register, recheck bit is never used
	wire        bad = |(FAULT_STATUS[6:2] & act_q[7:3]);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	always_ff @(posedge SYS_CLK)
		if (SYS_RST)
			act_q <= 8'h88;
		else if (wa)
			act_q <= REG_WDATA;
	property p_rsvd;
		REG_WR && REG_ADDR == 8'h4b ##1 REG_ADDR == 8'h4b |-> !REG_RDATA[2:0];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved set");
	property p_wvis;
		REG_WR && REG_ADDR == 8'h4c ##1 REG_ADDR == 8'h4c
			|-> REG_RDATA == $past(REG_WDATA);
	endproperty
	a_wvis: assert property (p_wvis) else $error("limit lost");
	property p_short;
		FAULT_STATUS.short_c && act_q[7] |=> !MICBIAS_EN;
	endproperty
	a_short: assert property (p_short) else $error("short on");
	property p_ot;
		FAULT_STATUS.ot && act_q[3] |=> !MICBIAS_EN;
	endproperty
	a_ot: assert property (p_ot) else $error("hot on");
	property p_hold;
		bad |=> !MICBIAS_EN;
	endproperty
	a_hold: assert property (p_hold) else $error("on in fault");
	property p_auto;
		!bad && act_q[1] && !MICBIAS_EN |=> MICBIAS_EN;
	endproperty
	a_auto: assert property (p_auto) else $error("no recovery");
	property p_man;
		wa && REG_WDATA[2] ##1 !bad |=> MICBIAS_EN;
	endproperty
	a_man: assert property (p_man) else $error("no recheck");
	property p_deb;
		$rose(FAULT_STATUS.ot) |-> $past(OT_RAW);
	endproperty
	a_deb: assert property (p_deb) else $error("early fault");
endmodule : diag_fault_monitor

bind diag_fault_policy diag_fault_monitor i_mon (.SYS_CLK, .SYS_RST,
	.REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA, .OT_RAW, .FAULT_STATUS,
	.MICBIAS_EN);

// File: verification/tb_diag_fault_policy.sv
// self-checking bench for the diagnostic fault policy
// assumes the port checker binds itself from its own file
`timescale 1ns/1ps
module tb_diag_fault_policy
	import diag_fault_pkg::*;
;
	logic        clk, rst, wr, lv, tv, xv, sr, ov, ot, en;
	logic [7:0]  ad, wd, rd;
	logic [1:0]  ds;
	logic [11:0] ls, ts, xs, lf, tf, xf;
	fault_vec_t  fs;
	int          failures, n_checks, cyc, m, b, o[3];
	int          dn[4] = '{16, 8, 4, 1};
	logic [7:0]  rv[6] = '{8'h00, 8'ha2, 8'h48, 8'hba, 8'h4b, 8'h88};
	diag_fault_policy i_dut (.SYS_CLK(clk), .SYS_RST(rst), .REG_WR(wr),
		.REG_ADDR(ad), .REG_WDATA(wd), .REG_RDATA(rd),
		.DEBOUNCE_COUNT_SEL(ds), .LOAD_SAMPLE(ls), .LOAD_VALID(lv),
		.TEMP_SAMPLE(ts), .TEMP_VALID(tv), .AUX_SAMPLE(xs), .AUX_VALID(xv),
		.SHORT_RAW(sr), .OV_RAW(ov), .OT_RAW(ot), .LOAD_FILT(lf),
		.TEMP_FILT(tf), .AUX_FILT(xf), .FAULT_STATUS(fs), .MICBIAS_EN(en));
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic chk(string n, logic [11:0] s, logic [11:0] e);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("wrong value %s exp %h saw %h", n, e, s);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic tk(int n);
		repeat (n) @(negedge clk);
	endtask : tk
	task automatic w(logic [7:0] a, logic [7:0] d);
		ad = a;
		wd = d;
		wr = 1;
		tk(1);
		wr = 0;
		// idle edge: a following write never re-raises wr in this step
		tk(1);
	endtask : w
	task automatic r(logic [7:0] a, logic [7:0] e);
		ad = a;
		#1 chk("reg", rd, e);
		tk(1);
	endtask : r
	// old value is the previous filter output
	function automatic int f(int p, int n, int k);
		if (k || m == 0 || m == 3)
			return n;
		return m == 1 ? (p + n) >> 1 : (3 * p + n) >> 2;
	endfunction : f
	task automatic s3(logic [11:0] l, logic [11:0] t, logic [11:0] x);
		{ls, ts, xs} = {l, t, x};
		{lv, tv, xv} = 3'h7;
		tk(1);
		{lv, tv, xv} = 3'h0;
		o[0] = f(o[0], l, b & 4);
		o[1] = f(o[1], t, b & 2);
		o[2] = f(o[2], x, b & 1);
		chk("load", lf, 12'(o[0]));
		chk("temp", tf, 12'(o[1]));
		chk("aux", xf, 12'(o[2]));
	endtask : s3
	always @(posedge clk)
		if (++cyc == 5000)
		begin
			failures++;
			stop_test;
		end
	initial
	begin
		{rst, wr, lv, tv, xv, sr, ov, ot, ad, wd, ds} = 'h80 << 18;
		{ls, ts, xs} = '0;
		void'($urandom(95115));
		tk(5);
		rst = 0;
		for (int k = 0; k < 6; k++)
			r(8'h4b + 8'(k), rv[k]);
		for (int k = 1; k < 5; k++)
		begin
			m = $urandom;
			w(8'h4b + 8'(k), 8'(m));
			r(ad, 8'(m));
			w(ad, rv[k]);
		end
		w(8'h51, 8'hff);
		r(8'h51, 8'h00);
		for (int i = 0; i < 32; i++)
		begin
			{m, b} = {i >> 3, i & 7};
			w(8'h4b, {m[1:0], b[2:0], 3'h7});
			r(8'h4b, {m[1:0], b[2:0], 3'h0});
			repeat (2) s3(12'($urandom), 12'($urandom), 12'($urandom));
		end
		for (int i = 0; i < 4; i++)
		begin
			ds = 2'(i);
			ot = 1;
			tk(dn[i] - 1);
			chk("ot", fs.ot, 0);
			tk(2);
			chk("ot", fs.ot, 1);
			tk(1);
			chk("en", en, 0);
			w(8'h50, 8'h8c);
			tk(2);
			chk("en", en, 0);
			ot = 0;
			tk(dn[i] + 2);
			chk("en", en, 0);
			w(8'h50, 8'h8c);
			tk(1);
			r(8'h50, 8'h88);
			chk("en", en, 1);
		end
		w(8'h50, 8'h8a);
		{ot, sr} = 2'h2;
		tk(8);
		chk("en", en, 0);
		ot = 0;
		tk(3);
		chk("en", en, 1);
		w(8'h50, 8'h8b);
		sr = 1;
		tk(4);
		chk("sc", fs.short_c, 0);
		w(8'h50, 8'h8a);
		tk(3);
		chk("en", en, 0);
		w(8'h50, 8'h12);
		{ov, sr} = 2'h2;
		tk(3);
		chk("en", en, 0);
		w(8'h50, 8'h02);
		tk(3);
		chk("en", en, 1);
		{ov, m, b} = 0;
		w(8'h50, 8'h62);
		w(8'h4b, 8'h00);
		s3(12'hfff, 12'h000, 12'hfff);
		tk(3);
		chk("fs", fs, 7'h22);
		chk("en", en, 0);
		s3(12'h000, 12'h000, 12'h000);
		tk(3);
		chk("fs", fs, 7'h11);
		s3(12'ha20, 12'h000, 12'hba0);
		tk(3);
		chk("fs", fs, 7'h00);
		chk("en", en, 1);
		stop_test;
	end
endmodule : tb_diag_fault_policy

// File: verilog/diag_fault_pkg.sv
// constants, register map and carrier types for the diagnostic fault policy
// assumes an 8-bit register port with 8-bit addresses and 12-bit samples
package diag_fault_pkg;

	localparam logic [7:0] ADDR_AVG_CFG    = 8'h4b;
	localparam logic [7:0] ADDR_HI_CURR    = 8'h4c;
	localparam logic [7:0] ADDR_LO_CURR    = 8'h4d;
	localparam logic [7:0] ADDR_AUX_UP     = 8'h4e;
	localparam logic [7:0] ADDR_AUX_LO     = 8'h4f;
	localparam logic [7:0] ADDR_ACTION     = 8'h50;

	localparam logic [7:0] RST_AVG_CFG     = 8'h00;
	localparam logic [7:0] RST_HI_CURR     = 8'ha2;
	localparam logic [7:0] RST_LO_CURR     = 8'h48;
	localparam logic [7:0] RST_AUX_UP      = 8'hba;
	localparam logic [7:0] RST_AUX_LO      = 8'h4b;
	localparam logic [7:0] RST_ACTION      = 8'h88;
	localparam logic [7:0] AVG_CFG_WMASK   = 8'hf8;

	// field positions in the fault action register
	localparam int BIT_OFF_SHORT     = 7;
	localparam int BIT_OFF_HIGH      = 6;
	localparam int BIT_OFF_LOW       = 5;
	localparam int BIT_OFF_OV        = 4;
	localparam int BIT_OFF_OT        = 3;
	localparam int BIT_RECHECK       = 2;
	localparam int BIT_AUTO_REC      = 1;
	localparam int BIT_SHORT_DET_OFF = 0;

	// field positions in the averaging register
	localparam int POS_AVG_MODE      = 6;
	localparam int BIT_BYP_LOAD      = 5;
	localparam int BIT_BYP_TEMP      = 4;
	localparam int BIT_BYP_AUX       = 3;

	// threshold code times 16 lands on the 12-bit scale
	localparam int THR_SHIFT         = 4;

	localparam logic [4:0] DEB_16    = 5'h10;
	localparam logic [4:0] DEB_8     = 5'h08;
	localparam logic [4:0] DEB_4     = 5'h04;
	localparam logic [4:0] DEB_NONE  = 5'h01;

	typedef enum logic [1:0] {
		AVG_OFF  = 2'h0,
		AVG_HALF = 2'h1,
		AVG_QTR  = 2'h2,
		AVG_RSVD = 2'h3
	} avg_mode_t;

	typedef enum logic [1:0] {
		ST_ON  = 2'b01,
		ST_OFF = 2'b10
	} bias_state_t;

	typedef struct packed {
		logic short_c;
		logic high_c;
		logic low_c;
		logic ov;
		logic ot;
		logic aux_high;
		logic aux_low;
	} fault_vec_t;

endpackage : diag_fault_pkg

// File: verilog/diag_fault_policy.sv
// diagnostic averaging, threshold compare and micbias powerdown policy
// assumes synchronous samples with per-channel valid strobes and raw
// short, overvoltage and overtemperature detector levels from analog
// Overview of operation
// - two-bit mode picks bypass, half or quarter averaging
// - load bypass bit skips load channel averaging
// - temp bypass bit skips temperature averaging
// - aux bypass bit skips aux channel averaging
// - high current limit 8 bits, reset a2
// - low current limit 8 bits, reset 48
// - aux upper limit 8 bits, reset ba
// - aux lower limit 8 bits, reset 4b
// - short fault powers micbias down when enabled
// - high current fault powers down when enabled
// - low current fault powers down when enabled
// - overvoltage fault powers down when enabled
// - overtemperature fault powers down when enabled
// - manual recheck restores power if faults gone
// - auto recovery enable restores power automatically
// - detect-off bit ignores short circuit faults
// - debounce of 16, 8, 4 or none
`timescale 1ns/1ps
module diag_fault_policy
	import diag_fault_pkg::*;
#(
	parameter int SAMPLE_W = 12
)(
	input  wire logic                SYS_CLK,
	input  wire logic                SYS_RST,
	input  wire logic                REG_WR,
	input  wire logic [7:0]          REG_ADDR,
	input  wire logic [7:0]          REG_WDATA,
	output logic      [7:0]          REG_RDATA,
	input  wire logic [1:0]          DEBOUNCE_COUNT_SEL,
	input  wire logic [SAMPLE_W-1:0] LOAD_SAMPLE,
	input  wire logic                LOAD_VALID,
	input  wire logic [SAMPLE_W-1:0] TEMP_SAMPLE,
	input  wire logic                TEMP_VALID,
	input  wire logic [SAMPLE_W-1:0] AUX_SAMPLE,
	input  wire logic                AUX_VALID,
	input  wire logic                SHORT_RAW,
	input  wire logic                OV_RAW,
	input  wire logic                OT_RAW,
	output logic [SAMPLE_W-1:0]      LOAD_FILT,
	output logic [SAMPLE_W-1:0]      TEMP_FILT,
	output logic [SAMPLE_W-1:0]      AUX_FILT,
	output fault_vec_t               FAULT_STATUS,
	output logic                     MICBIAS_EN
);

	localparam int NF = 7;

	logic [7:0]  avg_cfg_q;
	logic [7:0]  hi_curr_q;
	logic [7:0]  lo_curr_q;
	logic [7:0]  aux_up_q;
	logic [7:0]  aux_lo_q;
	logic [7:0]  action_q;
	logic [7:0]  action_d;
	bias_state_t state_q;
	bias_state_t state_d;

	wire avg_mode_t mode = avg_mode_t'(avg_cfg_q[POS_AVG_MODE +: 2]);

	// register writes; reserved averaging bits stay at reset value
	wire wr_avg = REG_WR && (REG_ADDR == ADDR_AVG_CFG);
	wire wr_hi  = REG_WR && (REG_ADDR == ADDR_HI_CURR);
	wire wr_lo  = REG_WR && (REG_ADDR == ADDR_LO_CURR);
	wire wr_up  = REG_WR && (REG_ADDR == ADDR_AUX_UP);
	wire wr_alo = REG_WR && (REG_ADDR == ADDR_AUX_LO);
	wire wr_act = REG_WR && (REG_ADDR == ADDR_ACTION);

	always_ff @(posedge SYS_CLK)
	begin
		if (SYS_RST)
		begin
			avg_cfg_q <= RST_AVG_CFG;
			hi_curr_q <= RST_HI_CURR;
			lo_curr_q <= RST_LO_CURR;
			aux_up_q  <= RST_AUX_UP;
			aux_lo_q  <= RST_AUX_LO;
			action_q  <= RST_ACTION;
		end
		else
		begin
			if (wr_avg)
				avg_cfg_q <= REG_WDATA & AVG_CFG_WMASK;
			if (wr_hi)
				hi_curr_q <= REG_WDATA;
			if (wr_lo)
				lo_curr_q <= REG_WDATA;
			if (wr_up)
				aux_up_q <= REG_WDATA;
			if (wr_alo)
				aux_lo_q <= REG_WDATA;
			action_q <= action_d;
		end
	end

	// recheck bit self-clears after one cycle
	always_comb
	begin
		action_d = action_q;
		action_d[BIT_RECHECK] = 1'b0;
		if (wr_act)
			action_d = REG_WDATA;
	end

	// read mux
	wire [7:0] rd_sel =
		(REG_ADDR == ADDR_AVG_CFG) ? avg_cfg_q :
		(REG_ADDR == ADDR_HI_CURR) ? hi_curr_q :
		(REG_ADDR == ADDR_LO_CURR) ? lo_curr_q :
		(REG_ADDR == ADDR_AUX_UP)  ? aux_up_q  :
		(REG_ADDR == ADDR_AUX_LO)  ? aux_lo_q  :
		(REG_ADDR == ADDR_ACTION)  ? action_q  : 8'h00;
	assign REG_RDATA = rd_sel;

	// moving average, one filter per channel
	logic [SAMPLE_W-1:0] smp [3];
	logic                vld [3];
	logic                byp [3];
	logic [SAMPLE_W-1:0] filt_q [3];

	assign smp[0] = LOAD_SAMPLE;
	assign smp[1] = TEMP_SAMPLE;
	assign smp[2] = AUX_SAMPLE;
	assign vld[0] = LOAD_VALID;
	assign vld[1] = TEMP_VALID;
	assign vld[2] = AUX_VALID;
	assign byp[0] = avg_cfg_q[BIT_BYP_LOAD];
	assign byp[1] = avg_cfg_q[BIT_BYP_TEMP];
	assign byp[2] = avg_cfg_q[BIT_BYP_AUX];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_avg
			// one local register per channel keeps a single driver
			logic [SAMPLE_W-1:0] val_q;
			wire [SAMPLE_W+1:0] old_x = {2'b00, filt_q[gi]};
			wire [SAMPLE_W+1:0] new_x = {2'b00, smp[gi]};
			wire [SAMPLE_W+1:0] half  = old_x + new_x;
			wire [SAMPLE_W+1:0] qtr   = (old_x << 1) + old_x + new_x;
			// reserved mode falls back to no averaging
			wire [SAMPLE_W-1:0] nxt =
				byp[gi]            ? smp[gi] :
				(mode == AVG_HALF) ? half[SAMPLE_W:1] :
				(mode == AVG_QTR)  ? qtr[SAMPLE_W+1:2] :
				smp[gi];
			always_ff @(posedge SYS_CLK)
			begin
				if (SYS_RST)
					val_q <= '0;
				else if (vld[gi])
					val_q <= nxt;
			end
			assign filt_q[gi] = val_q;
		end
	endgenerate

	assign LOAD_FILT = filt_q[0];
	assign TEMP_FILT = filt_q[1];
	assign AUX_FILT  = filt_q[2];

	// threshold compare on the 12-bit scale
	wire [SAMPLE_W-1:0] hi_thr = SAMPLE_W'({hi_curr_q, 4'h0});
	wire [SAMPLE_W-1:0] lo_thr = SAMPLE_W'({lo_curr_q, 4'h0});
	wire [SAMPLE_W-1:0] up_thr = SAMPLE_W'({aux_up_q, 4'h0});
	wire [SAMPLE_W-1:0] dn_thr = SAMPLE_W'({aux_lo_q, 4'h0});

	logic [NF-1:0] raw;
	assign raw[6] = SHORT_RAW & ~action_q[BIT_SHORT_DET_OFF];
	assign raw[5] = filt_q[0] > hi_thr;
	assign raw[4] = filt_q[0] < lo_thr;
	assign raw[3] = OV_RAW;
	assign raw[2] = OT_RAW;
	assign raw[1] = filt_q[2] > up_thr;
	assign raw[0] = filt_q[2] < dn_thr;

	// debounce: a fault flag changes only after a steady run
	wire [4:0] deb_len =
		(DEBOUNCE_COUNT_SEL == 2'h0) ? DEB_16 :
		(DEBOUNCE_COUNT_SEL == 2'h1) ? DEB_8  :
		(DEBOUNCE_COUNT_SEL == 2'h2) ? DEB_4  : DEB_NONE;

	logic [NF-1:0] flt_q;
	generate
		for (gi = 0; gi < NF; gi++)
		begin : g_deb
			logic [4:0] cnt_q;
			logic       flag_q;
			wire differ = raw[gi] != flag_q;
			wire done   = (cnt_q + 5'h01) >= deb_len;
			always_ff @(posedge SYS_CLK)
			begin
				if (SYS_RST)
				begin
					cnt_q <= 5'h00;
					flag_q <= 1'b0;
				end
				else if (!differ)
					cnt_q <= 5'h00;
				else if (done)
				begin
					cnt_q <= 5'h00;
					flag_q <= raw[gi];
				end
				else
					cnt_q <= cnt_q + 5'h01;
			end
			assign flt_q[gi] = flag_q;
		end
	endgenerate

	assign FAULT_STATUS = fault_vec_t'(flt_q);

	// only faults whose powerdown bit is set matter for micbias
	wire trip =
		(flt_q[6] & action_q[BIT_OFF_SHORT]) |
		(flt_q[5] & action_q[BIT_OFF_HIGH]) |
		(flt_q[4] & action_q[BIT_OFF_LOW]) |
		(flt_q[3] & action_q[BIT_OFF_OV]) |
		(flt_q[2] & action_q[BIT_OFF_OT]);
	wire recheck = action_q[BIT_RECHECK];
	wire auto_en = action_q[BIT_AUTO_REC];

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_ON:
				if (trip)
					state_d = ST_OFF;
			ST_OFF:
				if (!trip && (auto_en || recheck))
					state_d = ST_ON;
			default:
				state_d = ST_OFF;
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (SYS_RST)
			state_q <= ST_ON;
		else
			state_q <= state_d;
	end

	assign MICBIAS_EN = (state_q == ST_ON);

endmodule : diag_fault_policy
